// File: dsad_top.sv
`timescale 1ns/100ps
`default_nettype none
module dsad_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic addr_valid,
  input wire logic [7:0] addr_byte,
  input wire logic [15:0] drive_mode,
  input wire logic [7:0] fixed_head_drive,
  input wire logic [7:0] unit_kind,
  input wire logic primary_adapter,
  input wire logic [7:0] protect_read_sw,
  input wire logic ctrl_alt_sw,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_seek,
  input wire logic [31:0] cylinder_head_seek_field,
  output logic dec_valid,
  output logic [2:0] sc_sel,
  output logic [1:0] string_sel,
  output logic [2:0] drive_sel,
  output logic vol_sel,
  output logic [5:0] logical_addr,
  output logic cfg_ok,
  output logic alt_online,
  output logic primary_drive_only,
  output logic cmd_done,
  output logic cmd_reject,
  output logic seek_ok,
  output logic seek_bad,
  output logic [15:0] phys_cylinder,
  output logic [15:0] head_number,
  output logic zero_seek
);
  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic dec_valid;
    logic [2:0] sc_sel;
    logic [1:0] string_sel;
    logic [2:0] drive_sel;
    logic vol_sel;
    logic [5:0] logical_addr;
    logic cfg_ok;
    logic alt_online;
    logic primary_drive_only;
    logic cmd_done;
    logic cmd_reject;
    logic seek_ok;
    logic seek_bad;
    logic [15:0] phys_cylinder;
    logic [15:0] head_number;
    logic zero_seek;
    dsad_pkg::dsad_pu_t pu;
    logic [1:0] settle;
    logic alt_sel;
  } dsad_state_t;

  dsad_state_t st_ff;
  dsad_state_t nxt_st;
  logic [8:0] sync_q;
  logic [7:0] protect_q;
  logic alt_sw_q;

  // ********************************
  // Pin synchronisers
  // ********************************
  dsad_sync #(.W(9)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({ctrl_alt_sw, protect_read_sw}),
    .sync_out(sync_q)
  );
  assign protect_q = sync_q[7:0];
  assign alt_sw_q = sync_q[8];

  // ********************************
  // Next state
  // ********************************
  logic two_vol_any;
  logic alt_present;
  logic seen_none;
  logic cfg_good;
  logic [1:0] cur_mode;
  logic [15:0] cyl_in;
  logic [15:0] head_in;
  logic [15:0] cyl_max;
  logic [15:0] head_max;
  logic [15:0] conv_cyl;
  logic [15:0] fixed_hi;
  logic [16:0] dbl_cyl;

  always_comb begin
    two_vol_any = 1'b0;
    for (int i = 0; i < dsad_pkg::NUM_DRIVES; i++) begin
      if (drive_mode[2*i +: 2] == dsad_pkg::MODE_TWO_VOL) begin
        two_vol_any = 1'b1;
      end
    end

    // String composition check
    cfg_good = (unit_kind[1:0] == dsad_pkg::UNIT_PRIMARY);
    alt_present = 1'b0;
    seen_none = 1'b0;
    for (int u = 1; u < dsad_pkg::NUM_UNITS; u++) begin
      if (unit_kind[2*u +: 2] == dsad_pkg::UNIT_NONE) begin
        seen_none = 1'b1;
      end else begin
        if (seen_none || alt_present || unit_kind[2*u +: 2] == dsad_pkg::UNIT_PRIMARY) begin
          cfg_good = 1'b0;
        end
        if (unit_kind[2*u +: 2] == dsad_pkg::UNIT_ALT) begin
          alt_present = 1'b1;
        end
      end
    end
    if (alt_present && !primary_adapter) begin
      cfg_good = 1'b0;
    end

    nxt_st = st_ff;
    nxt_st.cfg_ok = cfg_good;
    nxt_st.cmd_done = 1'b0;
    nxt_st.cmd_reject = 1'b0;
    nxt_st.seek_ok = 1'b0;
    nxt_st.seek_bad = 1'b0;

    // Address byte decode
    nxt_st.dec_valid = addr_valid;
    if (addr_valid) begin
      if (two_vol_any) begin
        nxt_st.sc_sel = {1'b0, addr_byte[dsad_pkg::SC_HI], addr_byte[dsad_pkg::SC_LO2]};
        nxt_st.vol_sel = addr_byte[dsad_pkg::VOL_BIT];
      end else begin
        nxt_st.sc_sel = addr_byte[dsad_pkg::SC_HI:dsad_pkg::SC_LO3];
        nxt_st.vol_sel = 1'b0;
      end
      nxt_st.string_sel = addr_byte[dsad_pkg::STR_HI:dsad_pkg::STR_LO];
      nxt_st.drive_sel = addr_byte[dsad_pkg::DRV_HI:dsad_pkg::DRV_LO];
      nxt_st.logical_addr = addr_byte[dsad_pkg::LADDR_HI:0] & dsad_pkg::LADDR_MAX;
    end

    // Controller selection, frozen after power-up sampling
    case (st_ff.pu)
      dsad_pkg::PU_WAIT: begin
        nxt_st.settle = st_ff.settle + 2'h1;
        if (st_ff.settle == dsad_pkg::SYNC_SETTLE) begin
          nxt_st.alt_sel = alt_sw_q;
          nxt_st.pu = dsad_pkg::PU_RUN;
        end
      end
      dsad_pkg::PU_RUN: begin
        nxt_st.pu = dsad_pkg::PU_RUN;
      end
      default: begin
        nxt_st.pu = dsad_pkg::PU_WAIT;
      end
    endcase
    nxt_st.alt_online = alt_present && st_ff.alt_sel;
    nxt_st.primary_drive_only = alt_present && st_ff.alt_sel;

    // Command and seek checks against the addressed drive
    cur_mode = drive_mode[2*st_ff.drive_sel +: 2];
    cyl_in = cylinder_head_seek_field[dsad_pkg::CYL_HI:dsad_pkg::CYL_LO];
    head_in = cylinder_head_seek_field[dsad_pkg::HEAD_HI:dsad_pkg::HEAD_LO];
    dbl_cyl = {cyl_in, 1'b0};
    conv_cyl = 16'(dbl_cyl / dsad_pkg::CONV_DIV);
    case (cur_mode)
      dsad_pkg::MODE_NATIVE: begin
        cyl_max = dsad_pkg::CYL_MAX_NATIVE;
        head_max = dsad_pkg::HEAD_MAX_NATIVE;
        fixed_hi = dsad_pkg::FIXED_CYL_HI_NATIVE;
      end
      dsad_pkg::MODE_ONE_VOL: begin
        cyl_max = dsad_pkg::CYL_MAX_ONE_VOL;
        head_max = dsad_pkg::HEAD_MAX_COMPAT;
        fixed_hi = dsad_pkg::FIXED_CYL_HI_COMPAT;
      end
      default: begin
        cyl_max = dsad_pkg::CYL_MAX_TWO_VOL;
        head_max = dsad_pkg::HEAD_MAX_COMPAT;
        fixed_hi = dsad_pkg::FIXED_CYL_HI_COMPAT;
      end
    endcase

    if (cmd_valid) begin
      if (cmd_write && protect_q[st_ff.drive_sel]) begin
        nxt_st.cmd_reject = 1'b1;
      end else if (cmd_seek) begin
        if (cyl_in <= cyl_max && head_in <= head_max) begin
          nxt_st.seek_ok = 1'b1;
          nxt_st.cmd_done = 1'b1;
          nxt_st.head_number = head_in;
          if (cur_mode == dsad_pkg::MODE_NATIVE) begin
            nxt_st.phys_cylinder = cyl_in;
          end else if (cur_mode == dsad_pkg::MODE_TWO_VOL && st_ff.vol_sel) begin
            nxt_st.phys_cylinder = 16'(conv_cyl + dsad_pkg::CYL_OFFSET_VOL2);
          end else begin
            nxt_st.phys_cylinder = conv_cyl;
          end
          nxt_st.zero_seek = fixed_head_drive[st_ff.drive_sel]
            && cyl_in >= dsad_pkg::FIXED_CYL_LO && cyl_in <= fixed_hi
            && !(cur_mode == dsad_pkg::MODE_TWO_VOL && st_ff.vol_sel);
        end else begin
          nxt_st.seek_bad = 1'b1;
          nxt_st.cmd_reject = 1'b1;
        end
      end else begin
        nxt_st.cmd_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign dec_valid = st_ff.dec_valid;
  assign sc_sel = st_ff.sc_sel;
  assign string_sel = st_ff.string_sel;
  assign drive_sel = st_ff.drive_sel;
  assign vol_sel = st_ff.vol_sel;
  assign logical_addr = st_ff.logical_addr;
  assign cfg_ok = st_ff.cfg_ok;
  assign alt_online = st_ff.alt_online;
  assign primary_drive_only = st_ff.primary_drive_only;
  assign cmd_done = st_ff.cmd_done;
  assign cmd_reject = st_ff.cmd_reject;
  assign seek_ok = st_ff.seek_ok;
  assign seek_bad = st_ff.seek_bad;
  assign phys_cylinder = st_ff.phys_cylinder;
  assign head_number = st_ff.head_number;
  assign zero_seek = st_ff.zero_seek;

  // ********************************
  // Checks
  // ********************************
  sc_two_vol_a: assert property (@(posedge clk_sys) disable iff (rst)
    addr_valid && two_vol_any |=> sc_sel == {1'b0, $past(addr_byte[7:6])})
    else $error("storage control select wrong in two-volume string");
  sc_native_a: assert property (@(posedge clk_sys) disable iff (rst)
    addr_valid && !two_vol_any |=> sc_sel == $past(addr_byte[7:5]) && !vol_sel)
    else $error("storage control select wrong without two-volume drive");
  str_drv_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
    addr_valid |=> string_sel == $past(addr_byte[4:3]) && drive_sel == $past(addr_byte[2:0]))
    else $error("string or drive select wrong");
  vol_select_a: assert property (@(posedge clk_sys) disable iff (rst)
    addr_valid && two_vol_any |=> vol_sel == $past(addr_byte[5]))
    else $error("volume select wrong");
  write_protect_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_valid && cmd_write && protect_q[drive_sel] |=> cmd_reject && !cmd_done)
    else $error("write executed on protected drive");
  rw_accept_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_valid && !cmd_seek && !(cmd_write && protect_q[drive_sel]) |=> cmd_done)
    else $error("command refused on writable drive");
  ctrl_frozen_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.pu == dsad_pkg::PU_RUN |=> $stable(st_ff.alt_sel))
    else $error("controller selection changed while running");
  native_limit_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_valid && cmd_seek && cur_mode == dsad_pkg::MODE_NATIVE
    && !(cmd_write && protect_q[drive_sel]) && head_in > dsad_pkg::HEAD_MAX_NATIVE
    |=> seek_bad && cmd_reject && !seek_ok)
    else $error("native head limit not enforced");
  vol2_offset_a: assert property (@(posedge clk_sys) disable iff (rst)
    seek_ok && $past(cur_mode) == dsad_pkg::MODE_TWO_VOL && $past(vol_sel)
    |-> phys_cylinder >= dsad_pkg::CYL_OFFSET_VOL2)
    else $error("second volume offset missing");
  zero_vol2_a: assert property (@(posedge clk_sys) disable iff (rst)
    zero_seek && $past(cur_mode) == dsad_pkg::MODE_TWO_VOL |-> !$past(vol_sel))
    else $error("zero-seek region reached through second volume");
endmodule : dsad_top
`default_nettype wire

// File: dsad_pkg.sv
package dsad_pkg;
  // ********************************
  // Address byte fields (bit 7 is the MSB)
  // ********************************
  localparam int ADDR_W = 8;
  localparam int SC_HI = 7;
  localparam int SC_LO2 = 6;
  localparam int SC_LO3 = 5;
  localparam int STR_HI = 4;
  localparam int STR_LO = 3;
  localparam int DRV_HI = 2;
  localparam int DRV_LO = 0;
  localparam int VOL_BIT = 5;
  localparam int LADDR_HI = 5;
  localparam logic [5:0] LADDR_MAX = 6'h3F;
  localparam int NUM_DRIVES = 8;
  localparam int NUM_UNITS = 4;

  // ********************************
  // Recording modes
  // ********************************
  localparam logic [1:0] MODE_NATIVE = 2'h0;
  localparam logic [1:0] MODE_ONE_VOL = 2'h1;
  localparam logic [1:0] MODE_TWO_VOL = 2'h2;

  // ********************************
  // Unit kinds in the string
  // ********************************
  localparam logic [1:0] UNIT_NONE = 2'h0;
  localparam logic [1:0] UNIT_PRIMARY = 2'h1;
  localparam logic [1:0] UNIT_DRIVE = 2'h2;
  localparam logic [1:0] UNIT_ALT = 2'h3;

  // ********************************
  // Seek field and limits
  // ********************************
  localparam int SEEK_W = 32;
  localparam int CYL_HI = 31;
  localparam int CYL_LO = 16;
  localparam int HEAD_HI = 15;
  localparam int HEAD_LO = 0;
  localparam logic [15:0] CYL_MAX_NATIVE = 16'h022F;
  localparam logic [15:0] HEAD_MAX_NATIVE = 16'h001D;
  localparam logic [15:0] CYL_MAX_ONE_VOL = 16'h032E;
  localparam logic [15:0] CYL_MAX_TWO_VOL = 16'h019A;
  localparam logic [15:0] HEAD_MAX_COMPAT = 16'h0012;
  localparam logic [15:0] CYL_OFFSET_VOL2 = 16'h0112;
  localparam logic [16:0] CONV_DIV = 17'h00003;
  localparam logic [15:0] FIXED_CYL_LO = 16'h0001;
  localparam logic [15:0] FIXED_CYL_HI_NATIVE = 16'h0002;
  localparam logic [15:0] FIXED_CYL_HI_COMPAT = 16'h0003;

  // ********************************
  // Power-up sampling
  // ********************************
  localparam logic [1:0] SYNC_SETTLE = 2'h2;

  typedef enum logic [0:0] {PU_WAIT, PU_RUN} dsad_pu_t;
endpackage : dsad_pkg

// File: dsad_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dsad_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dsad_sync_t;

  dsad_sync_t st_ff;
  dsad_sync_t nxt_st;

  always_comb begin
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.s2;
endmodule : dsad_sync
`default_nettype wire

// File: dsad_chan_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsad_chan_model (
  input wire logic clk_sys,
  output logic addr_valid,
  output logic [7:0] addr_byte,
  output logic cmd_valid,
  output logic cmd_write,
  output logic cmd_seek,
  output logic [31:0] cylinder_head_seek_field
);
  initial begin
    addr_valid = 1'b0;
    addr_byte = 8'h00;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_seek = 1'b0;
    cylinder_head_seek_field = 32'h00000000;
  end
  // ********************************
  // Requests; released lines show the inverse of the last value
  // ********************************
  task automatic send_addr(input logic [7:0] b);
    addr_byte = b;
    addr_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    addr_valid = 1'b0;
    addr_byte = ~b;
  endtask : send_addr
  task automatic send_cmd(input logic wr, input logic sk, input logic [31:0] f);
    cmd_write = wr;
    cmd_seek = sk;
    cylinder_head_seek_field = f;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    cmd_write = ~wr;
    cmd_seek = ~sk;
    cylinder_head_seek_field = ~f;
  endtask : send_cmd
endmodule : dsad_chan_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys, rst, addr_valid, cmd_valid, cmd_write, cmd_seek, primary_adapter, ctrl_alt_sw;
  logic [7:0] addr_byte, fixed_head_drive, unit_kind, protect_read_sw;
  logic [15:0] drive_mode, phys_cylinder, head_number;
  logic [31:0] cylinder_head_seek_field;
  logic dec_valid, vol_sel, cfg_ok, alt_online, primary_drive_only, cmd_done, cmd_reject;
  logic seek_ok, seek_bad, zero_seek;
  logic [2:0] sc_sel, drive_sel;
  logic [1:0] string_sel;
  logic [5:0] logical_addr;
  int failures, samples_checked, cycles;

  dsad_top dut (.clk_sys(clk_sys), .rst(rst), .addr_valid(addr_valid), .addr_byte(addr_byte),
    .drive_mode(drive_mode), .fixed_head_drive(fixed_head_drive), .unit_kind(unit_kind),
    .primary_adapter(primary_adapter), .protect_read_sw(protect_read_sw),
    .ctrl_alt_sw(ctrl_alt_sw), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_seek(cmd_seek), .cylinder_head_seek_field(cylinder_head_seek_field),
    .dec_valid(dec_valid), .sc_sel(sc_sel), .string_sel(string_sel), .drive_sel(drive_sel),
    .vol_sel(vol_sel), .logical_addr(logical_addr), .cfg_ok(cfg_ok), .alt_online(alt_online),
    .primary_drive_only(primary_drive_only), .cmd_done(cmd_done), .cmd_reject(cmd_reject),
    .seek_ok(seek_ok), .seek_bad(seek_bad), .phys_cylinder(phys_cylinder),
    .head_number(head_number), .zero_seek(zero_seek));
  dsad_chan_model chan (.clk_sys(clk_sys), .addr_valid(addr_valid), .addr_byte(addr_byte),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_seek(cmd_seek),
    .cylinder_head_seek_field(cylinder_head_seek_field));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  // ********************************
  // Shared helpers
  // ********************************
  task automatic print_verdict();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic do_reset();
    rst = 1'b1;
    step(20);
    rst = 1'b0;
    step(6);
  endtask : do_reset
  task automatic dec_chk(input logic [7:0] b, input logic two);
    chan.send_addr(b);
    chk("dec_valid", 16'h0001, 16'(dec_valid));
    chk("sc_sel", two ? 16'({b[7], b[6]}) : 16'(b[7:5]), 16'(sc_sel));
    chk("string_sel", 16'(b[4:3]), 16'(string_sel));
    chk("drive_sel", 16'(b[2:0]), 16'(drive_sel));
    chk("vol_sel", 16'(two & b[5]), 16'(vol_sel));
    chk("logical_addr", 16'(b[5:0]), 16'(logical_addr));
    step(1);
    chk("dec_valid", 16'h0000, 16'(dec_valid));
  endtask : dec_chk
  task automatic cmd_chk(input logic wr, input logic rej);
    chan.send_cmd(wr, 1'b0, 32'h00000000);
    chk("cmd_done", 16'(!rej), 16'(cmd_done));
    chk("cmd_reject", 16'(rej), 16'(cmd_reject));
    step(1);
  endtask : cmd_chk
  task automatic seek_chk(input logic [15:0] cyl, input logic [15:0] hd, input logic ok,
                          input logic [15:0] phys, input logic zs);
    chan.send_cmd(1'b0, 1'b1, {cyl, hd});
    chk("seek_ok", 16'(ok), 16'(seek_ok));
    chk("seek_bad", 16'(!ok), 16'(seek_bad));
    chk("cmd_reject", 16'(!ok), 16'(cmd_reject));
    chk("cmd_done", 16'(ok), 16'(cmd_done));
    if (ok) begin
      chk("phys_cylinder", phys, phys_cylinder);
      chk("head_number", hd, head_number);
      chk("zero_seek", 16'(zs), 16'(zero_seek));
    end
    step(1);
  endtask : seek_chk
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_decode();
    logic [7:0] bytes [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
    drive_mode = 16'h0001;
    step(2);
    foreach (bytes[i]) dec_chk(bytes[i], 1'b0);
    drive_mode = 16'h2001;
    step(2);
    foreach (bytes[i]) dec_chk(bytes[i], 1'b1);
  endtask : t_decode
  task automatic t_protect();
    drive_mode = 16'h0000;
    protect_read_sw = 8'h04;
    step(4);
    dec_chk(8'h02, 1'b0);
    cmd_chk(1'b1, 1'b1);
    cmd_chk(1'b0, 1'b0);
    protect_read_sw = 8'h00;
    step(4);
    cmd_chk(1'b1, 1'b0);
  endtask : t_protect
  task automatic t_seek();
    drive_mode = 16'h0200;
    fixed_head_drive = 8'h11;
    step(2);
    dec_chk(8'h00, 1'b1);
    seek_chk(16'h022F, 16'h001D, 1'b1, 16'h022F, 1'b0);
    seek_chk(16'h0230, 16'h0000, 1'b0, 16'h0000, 1'b0);
    seek_chk(16'h0000, 16'h001E, 1'b0, 16'h0000, 1'b0);
    seek_chk(16'h0002, 16'h0005, 1'b1, 16'h0002, 1'b1);
    drive_mode = 16'h0201;
    seek_chk(16'h032E, 16'h0012, 1'b1, 16'h021E, 1'b0);
    seek_chk(16'h032F, 16'h0000, 1'b0, 16'h0000, 1'b0);
    dec_chk(8'h24, 1'b1);
    seek_chk(16'h019A, 16'h0012, 1'b1, 16'h0223, 1'b0);
    seek_chk(16'h0001, 16'h0000, 1'b1, 16'h0112, 1'b0);
    seek_chk(16'h019B, 16'h0000, 1'b0, 16'h0000, 1'b0);
    dec_chk(8'h04, 1'b1);
    seek_chk(16'h0003, 16'h0012, 1'b1, 16'h0002, 1'b1);
    seek_chk(16'h0004, 16'h0000, 1'b1, 16'h0002, 1'b0);
    seek_chk(16'h0000, 16'h0013, 1'b0, 16'h0000, 1'b0);
  endtask : t_seek
  task automatic t_config();
    logic [7:0] uk [10] = '{8'h01, 8'hE9, 8'hE9, 8'h00, 8'h02, 8'hAD, 8'h29, 8'h89, 8'h05,
                           8'h3D};
    logic ad [10] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    logic ex [10] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    foreach (uk[i]) begin
      unit_kind = uk[i];
      primary_adapter = ad[i];
      step(2);
      chk("cfg_ok", 16'(ex[i]), 16'(cfg_ok));
    end
  endtask : t_config
  task automatic t_ctrl();
    unit_kind = 8'hE9;
    primary_adapter = 1'b1;
    ctrl_alt_sw = 1'b1;
    do_reset();
    chk("alt_online", 16'h0001, 16'(alt_online));
    chk("primary_drive_only", 16'h0001, 16'(primary_drive_only));
    ctrl_alt_sw = 1'b0;
    step(6);
    chk("alt_online", 16'h0001, 16'(alt_online));
    do_reset();
    chk("alt_online", 16'h0000, 16'(alt_online));
    ctrl_alt_sw = 1'b1;
    step(6);
    chk("alt_online", 16'h0000, 16'(alt_online));
    do_reset();
    unit_kind = 8'h29;
    step(2);
    chk("alt_online", 16'h0000, 16'(alt_online));
  endtask : t_ctrl

  initial begin
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    rst = 1'b1;
    drive_mode = 16'h0000;
    fixed_head_drive = 8'h00;
    unit_kind = 8'hE9;
    primary_adapter = 1'b1;
    protect_read_sw = 8'h00;
    ctrl_alt_sw = 1'b0;
    do_reset();
    t_decode();
    t_protect();
    t_seek();
    t_config();
    t_ctrl();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
